// File: logic/flash_status_pkg.sv
// Package of constants and types for the flash write status reporting block.
package flash_status_pkg;

    // ==========================================================
    // Timing constants
    // ==========================================================
    // Reference clock rate in kHz.
    localparam int unsigned CLK_KHZ          = 40000;
    // Toggling time when every selected erase sector is protected, in us.
    localparam int unsigned ERASE_PROT_US    = 100;
    // Toggling time when a program targets a protected sector, in us.
    localparam int unsigned PROG_PROT_US     = 1000;
    // Cycle counts derived from the times above (longest time, rounded down).
    localparam int unsigned ERASE_PROT_CYC   = ERASE_PROT_US * CLK_KHZ / 1000;
    localparam int unsigned PROG_PROT_CYC    = PROG_PROT_US * CLK_KHZ / 1000;
    // Burst clock edges of wait during the initial burst access.
    localparam logic [1:0]  INIT_WAIT_EDGES  = 2'h3;
    // Burst clock edges of wait after a boundary, normal and extended.
    localparam logic [1:0]  WAIT_ONE         = 2'h1;
    localparam logic [1:0]  WAIT_TWO         = 2'h2;

    // ==========================================================
    // Field layout
    // ==========================================================
    // Width of the hold counter for protected-sector toggling.
    localparam int unsigned HOLD_W           = 16;
    // Word address width and the last address before a 64-word boundary.
    localparam int unsigned ADDR_W           = 22;
    localparam int unsigned BOUND_W          = 6;
    localparam logic [5:0]  BOUND_LAST       = 6'h3f;
    // Bit positions in the low data byte.
    localparam int unsigned TOGGLE_POS       = 6;
    localparam int unsigned TIMEOUT_POS      = 5;
    localparam int unsigned SECTOR_POS       = 2;
    // Reset values.
    localparam logic [7:0]  BYTE_RESET       = 8'h00;
    localparam logic [1:0]  WAIT_RESET       = 2'h0;

    // ==========================================================
    // Embedded operation states
    // ==========================================================
    typedef enum logic [2:0] {
        OP_IDLE      = 3'h0,
        OP_PROG      = 3'h1,
        OP_ERASE     = 3'h3,
        OP_SUSP      = 3'h2,
        OP_SUSP_PROG = 3'h6,
        OP_PROT_HOLD = 3'h7
    } op_state_e;

endpackage

// File: logic/flash_write_status_reporting.sv
// Write status reporting: ready/wait pin and toggle status bits.
//
// What this block does
// - Sync mode: low ready means wait one clock.
// - Configuration option makes low mean two clocks.
// - Sync mode: ready pin enabled by chip select only.
// - Wait at initial access and each 64-word boundary.
// - Async: open-drain low while erasing or programming.
// - Async busy valid from final write strobe rise.
// - Toggle bit flips per read while operation runs.
// - Toggle readable anywhere in busy bank, from strobe.
// - All sectors protected: toggle about 100 us.
// - Partially protected erase skips protected sectors silently.
// - Protected program address: toggle about 1 ms.
// - Erase suspend stops toggling; active erase toggles.
// - Suspend-program toggles; sector bit not meaningful.
// - Toggle changes only across select or enable deassert.
// - Sector bit toggles only in selected erase sectors.
// - Suspended, unselected sector reads return array data.
// - Timeout bit set when pulse limit exceeded.
module flash_write_status_reporting
    import flash_status_pkg::*;
#(
    parameter int unsigned PROG_PROT_CYCLES = PROG_PROT_CYC
) (
    input  wire logic                ref_clk,          // 40 MHz clock.
    input  wire logic                resetn,           // Async reset, low.
    input  wire logic                burst_clk,        // Burst clock pin.
    input  wire logic                ce_n,             // Chip select pin.
    input  wire logic                oe_n,             // Output enable pin.
    input  wire logic                we_n,             // Write strobe pin.
    input  wire logic                sync_mode,        // 1: burst mode.
    input  wire logic                wait_two,         // 1: two-clock wait.
    input  wire logic [ADDR_W-1:0]   burst_start_addr, // First burst address.
    input  wire logic                prog_cmd,         // Program sequence armed.
    input  wire logic                prog_protected,   // Target protected.
    input  wire logic                erase_cmd,        // Erase sequence armed.
    input  wire logic                erase_all_prot,   // All targets protected.
    input  wire logic                suspend_cmd,      // Suspend pulse.
    input  wire logic                resume_cmd,       // Resume pulse.
    input  wire logic                algo_done,        // Algorithm done pulse.
    input  wire logic                pulse_limit_hit,  // Pulse limit pulse.
    input  wire logic                reset_cmd,        // Reset command pulse.
    input  wire logic                addr_busy_bank,   // Read in busy bank.
    input  wire logic                addr_erase_sel,   // Read in erase sector.
    input  wire logic [7:0]          array_data,       // Array low byte.
    output logic      [7:0]          data_low_byte,    // Read data low byte.
    output logic                     status_shown,     // 1: status on bus.
    output logic                     rdy_out,          // Ready pin level.
    output logic                     rdy_oe,           // Ready pin enable.
    output logic                     busy              // Algorithm running.
);

    // ==========================================================
    // Pin synchronisers
    // ==========================================================
    logic [1:0] bclk_sync;     // Burst clock two-stage synchroniser.
    logic [1:0] ce_sync;       // Chip select synchroniser.
    logic [1:0] oe_sync;       // Output enable synchroniser.
    logic [1:0] we_sync;       // Write strobe synchroniser.
    logic       bclk_q;        // Previous synchronised burst clock.
    logic       we_q;          // Previous synchronised write strobe.
    logic       rd_q;          // Previous read-cycle state.

    // Every pin passes two flip-flops before any logic reads it.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            bclk_sync <= 2'h0;
            ce_sync   <= 2'h3;
            oe_sync   <= 2'h3;
            we_sync   <= 2'h3;
        end else begin
            bclk_sync <= {bclk_sync[0], burst_clk};
            ce_sync   <= {ce_sync[0], ce_n};
            oe_sync   <= {oe_sync[0], oe_n};
            we_sync   <= {we_sync[0], we_n};
        end
    end

    logic ce_act;    // Chip selected.
    logic rd_act;    // Read cycle in progress.
    assign ce_act = !ce_sync[1];
    assign rd_act = !ce_sync[1] && !oe_sync[1];

    // Edge history taken from the second synchroniser stages only.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            bclk_q <= 1'b0;
            we_q   <= 1'b1;
            rd_q   <= 1'b0;
        end else begin
            bclk_q <= bclk_sync[1];
            we_q   <= we_sync[1];
            rd_q   <= rd_act;
        end
    end

    logic bclk_rise;  // Burst clock rising edge.
    logic we_rise;    // Write strobe rising edge.
    logic rd_end;     // Select or enable deasserted after a read.
    logic rd_start;   // New read cycle begins.
    assign bclk_rise = bclk_sync[1] && !bclk_q;
    assign we_rise   = we_sync[1] && !we_q;
    assign rd_end    = rd_q && !rd_act;
    assign rd_start  = rd_act && !rd_q;

    // ==========================================================
    // Embedded operation state
    // ==========================================================
    op_state_e           state_reg;  // Current operation state.
    op_state_e           ret_reg;    // State the hold returns to.
    logic [HOLD_W-1:0]   hold_reg;   // Protected-sector toggle timer.

    logic start_prog;   // Program starts at the final strobe rise.
    logic start_erase;  // Erase starts at the final strobe rise.
    // Busy timing starts at the rising edge of the last write strobe.
    // Busy from strobe
    assign start_prog  = we_rise && prog_cmd;
    assign start_erase = we_rise && erase_cmd;

    // Operation sequencing; a reset command returns to reading array data, or from suspend-program to erase-suspend-read.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            state_reg <= OP_IDLE;
            ret_reg   <= OP_IDLE;
            hold_reg  <= '0;
        end else if (reset_cmd) begin
            // Suspend-program goes back to erase-suspend-read on reset.
            state_reg <= (state_reg == OP_SUSP_PROG) ? OP_SUSP : OP_IDLE;
            hold_reg  <= '0;
        end else begin
            case (state_reg)
                OP_IDLE: begin
                    if (start_prog && prog_protected) begin
                        state_reg <= OP_PROT_HOLD;
                        ret_reg   <= OP_IDLE;
                        hold_reg  <= HOLD_W'(PROG_PROT_CYCLES - 1);
                    end else if (start_prog) begin
                        state_reg <= OP_PROG;
                    end else if (start_erase && erase_all_prot) begin
                        state_reg <= OP_PROT_HOLD;
                        ret_reg   <= OP_IDLE;
                        hold_reg  <= HOLD_W'(ERASE_PROT_CYC - 1);
                    end else if (start_erase) begin
                        state_reg <= OP_ERASE;
                    end
                end
                OP_PROG: begin
                    if (algo_done) begin
                        state_reg <= OP_IDLE;
                    end
                end
                OP_ERASE: begin
                    if (algo_done) begin
                        state_reg <= OP_IDLE;
                    end else if (suspend_cmd) begin
                        state_reg <= OP_SUSP;
                    end
                end
                OP_SUSP: begin
                    if (resume_cmd) begin
                        state_reg <= OP_ERASE;
                    end else if (start_prog && prog_protected) begin
                        state_reg <= OP_PROT_HOLD;
                        ret_reg   <= OP_SUSP;
                        hold_reg  <= HOLD_W'(PROG_PROT_CYCLES - 1);
                    end else if (start_prog) begin
                        state_reg <= OP_SUSP_PROG;
                    end
                end
                OP_SUSP_PROG: begin
                    if (algo_done) begin
                        state_reg <= OP_SUSP;
                    end
                end
                OP_PROT_HOLD: begin
                    // Hold expiry returns the bank to its earlier mode.
                    if (hold_reg == '0) begin
                        state_reg <= ret_reg;
                    end else begin
                        hold_reg <= hold_reg - 1'b1;
                    end
                end
                default: begin
                    state_reg <= OP_IDLE;
                end
            endcase
        end
    end

    logic running;   // Program or erase in progress, toggling enabled.
    logic erasing;   // An erase is active or suspended, with no program running in suspend.
    assign running = (state_reg == OP_PROG) || (state_reg == OP_ERASE) ||
                     (state_reg == OP_SUSP_PROG) ||
                     (state_reg == OP_PROT_HOLD);
    assign erasing = (state_reg == OP_ERASE) || (state_reg == OP_SUSP);

    // ==========================================================
    // Toggle and timeout bits
    // ==========================================================
    logic toggle_reg;    // Toggle status bit.
    logic sector_reg;    // Sector toggle status bit.
    logic timeout_reg;   // Timeout error bit.
    logic sel_reg;       // Read targets a selected erase sector.

    // Sector selection is captured when a read cycle starts.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            sel_reg <= 1'b0;
        end else if (rd_start) begin
            sel_reg <= addr_erase_sel;
        end
    end

    // Toggle bits change only when a read cycle is closed by the host.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            toggle_reg <= 1'b0;
            sector_reg <= 1'b0;
        end else if (rd_end) begin
            if (running) begin
                toggle_reg <= !toggle_reg;
            end
            if (erasing && sel_reg) begin
                sector_reg <= !sector_reg;
            end
        end
    end

    // A pulse limit event wins over a reset command in the same cycle.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            timeout_reg <= 1'b0;
        end else if (pulse_limit_hit && running) begin
            timeout_reg <= 1'b1;
        end else if (reset_cmd) begin
            timeout_reg <= 1'b0;
        end
    end

    // ==========================================================
    // Read data multiplexer
    // ==========================================================
    logic show_status;   // Status, not array data, answers the read.
    logic [7:0] stat_byte;  // Assembled status byte.
    assign show_status = addr_busy_bank && (state_reg != OP_IDLE) &&
                         !((state_reg == OP_SUSP) && !sel_reg);

    always_comb begin
        stat_byte              = BYTE_RESET;
        stat_byte[TOGGLE_POS]  = toggle_reg;
        stat_byte[TIMEOUT_POS] = timeout_reg;
        // The sector bit holds still while programming in suspend.
        stat_byte[SECTOR_POS]  = sector_reg;
    end

    // Registered read data toward the bus.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            data_low_byte <= BYTE_RESET;
            status_shown  <= 1'b0;
        end else begin
            data_low_byte <= show_status ? stat_byte : array_data;
            status_shown  <= show_status;
        end
    end

    // ==========================================================
    // Burst wait tracking
    // ==========================================================
    logic [ADDR_W-1:0] baddr_reg;  // Current burst word address.
    logic [1:0]        wait_reg;   // Burst clock edges still to wait.
    logic              ce_q;       // Previous chip select state.

    // Wait counts are loaded at the initial access and at each boundary.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            baddr_reg <= '0;
            wait_reg  <= WAIT_RESET;
            ce_q      <= 1'b0;
        end else begin
            ce_q <= ce_act;
            if (ce_act && !ce_q) begin
                baddr_reg <= burst_start_addr;
                wait_reg  <= INIT_WAIT_EDGES;
            end else if (!ce_act) begin
                wait_reg <= WAIT_RESET;
            end else if (bclk_rise) begin
                if (wait_reg != WAIT_RESET) begin
                    wait_reg <= wait_reg - 1'b1;
                end else begin
                    baddr_reg <= baddr_reg + 1'b1;
                    if (baddr_reg[BOUND_W-1:0] == BOUND_LAST) begin
                        wait_reg <= wait_two ? WAIT_TWO : WAIT_ONE;
                    end
                end
            end
        end
    end

    // ==========================================================
    // Ready pin
    // ==========================================================
    logic op_busy;   // Erase or program running for the pin.
    assign op_busy = (state_reg == OP_PROG) || (state_reg == OP_ERASE) ||
                     (state_reg == OP_SUSP_PROG);

    // Pin drive depends on the mode; the output enable pin plays no part.
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            rdy_out <= 1'b0;
            rdy_oe  <= 1'b0;
            busy    <= 1'b0;
        end else begin
            busy <= op_busy;
            if (sync_mode) begin
                // Chip select enables
                // Drive waits a cycle, until the initial wait is loaded,
                // so no ready blip shows as the frame opens.
                rdy_oe  <= ce_act && ce_q;
                rdy_out <= (wait_reg == WAIT_RESET);
            end else begin
                rdy_oe  <= op_busy;
                rdy_out <= 1'b0;
            end
        end
    end

endmodule

// File: dv/flash_status_checker_properties.sv
// Port checker of the flash write status reporting block.
module flash_status_checker
    import flash_status_pkg::*;
#(
    parameter int unsigned PROG_PROT_CYCLES = PROG_PROT_CYC
) (
    input wire logic       ref_clk,
    input wire logic       resetn,
    input wire logic       ce_n,
    input wire logic       oe_n,
    input wire logic       we_n,
    input wire logic       sync_mode,
    input wire logic       prog_cmd,
    input wire logic       prog_protected,
    input wire logic       algo_done,
    input wire logic [7:0] array_data,
    input wire logic [7:0] data_low_byte,
    input wire logic       status_shown,
    input wire logic       rdy_out,
    input wire logic       rdy_oe,
    input wire logic       busy
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Edge count after reset, so that stale past values are ignored.
    logic [1:0] up_reg;
    always_ff @(posedge ref_clk or negedge resetn) begin
        if (!resetn) begin
            up_reg <= 2'h0;
        end else if (up_reg != 2'h3) begin
            up_reg <= up_reg + 2'h1;
        end
    end
    default clocking cb_main @(posedge ref_clk);
    endclocking
    default disable iff (!resetn);
    property p_async_rdy;
        !sync_mode && !$past(sync_mode) |-> rdy_oe == busy && !rdy_out;
    endproperty
    a_async_rdy: assert property (p_async_rdy)
        else $error("ready pin does not follow busy in async mode");
    property p_start;
        $rose(we_n) && prog_cmd && !prog_protected && !sync_mode && !busy
        |-> ##[3:6] (busy && rdy_oe && !rdy_out);
    endproperty
    a_start: assert property (p_start)
        else $error("busy not shown after final write strobe");
    property p_done;
        busy && algo_done |-> ##[1:4] !busy;
    endproperty
    a_done: assert property (p_done)
        else $error("busy stays after algorithm end");
    property p_data;
        up_reg == 2'h3 && !status_shown |-> data_low_byte == $past(array_data);
    endproperty
    a_data: assert property (p_data)
        else $error("array byte not passed through");
    property p_pad;
        status_shown |-> (data_low_byte & 8'h9b) == 8'h00;
    endproperty
    a_pad: assert property (p_pad)
        else $error("unused status bits not zero");
    property p_toggle;
        (!ce_n && !oe_n) [*6] ##0 (status_shown && $past(status_shown))
        |-> $stable(data_low_byte[TOGGLE_POS]);
    endproperty
    a_toggle: assert property (p_toggle)
        else $error("toggle bit moved inside one read");
    property p_burst_init;
        sync_mode && $fell(ce_n) |-> ##[3:5] (rdy_oe && !rdy_out);
    endproperty
    a_burst_init: assert property (p_burst_init)
        else $error("no wait at initial burst access");
    property p_ce_only;
        (sync_mode && ce_n) [*4] |-> !rdy_oe;
    endproperty
    a_ce_only: assert property (p_ce_only)
        else $error("ready pin driven while deselected");
    c_busy: cover property ($rose(busy));
    c_wait: cover property (sync_mode && rdy_oe && $fell(rdy_out));
    c_toggle: cover property (status_shown && $changed(data_low_byte));
endmodule

// File: dv/flash_host_model.sv
// Host controller model driving select, enable, strobe and burst clock.
module flash_host_model
    import flash_status_pkg::*;
(
    input  wire logic       ref_clk,
    input  wire logic [7:0] data_low_byte,
    output logic            ce_n,
    output logic            oe_n,
    output logic            we_n,
    output logic            burst_clk
);
    timeunit 1ns;
    timeprecision 1ps;
    // ==========================================================
    // Idle bus: deselected, and the burst clock stands still.
    initial begin
        ce_n = 1'b1;
        oe_n = 1'b1;
        we_n = 1'b1;
        burst_clk = 1'b0;
    end
    // Deassert between reads.
    // A read window; a is taken early, b late in the same window.
    task automatic rd(output logic [7:0] a, output logic [7:0] b);
        @(negedge ref_clk);
        ce_n = 1'b0;
        oe_n = 1'b0;
        repeat (6) @(negedge ref_clk);
        a = data_low_byte;
        repeat (8) @(negedge ref_clk);
        b = data_low_byte;
        ce_n = 1'b1;
        oe_n = 1'b1;
        repeat (6) @(negedge ref_clk);
    endtask
    // Final write strobe of a command sequence.
    task automatic wr();
        @(negedge ref_clk);
        ce_n = 1'b0;
        we_n = 1'b0;
        repeat (4) @(negedge ref_clk);
        we_n = 1'b1;
        ce_n = 1'b1;
        repeat (8) @(negedge ref_clk);
    endtask
    // Chip select alone, as a burst frame opens or closes.
    task automatic sel(input logic v);
        @(negedge ref_clk);
        ce_n = v;
        repeat (6) @(negedge ref_clk);
    endtask
    // One burst clock period.
    // The host gives each period whatever the ready level, and takes no word.
    task automatic bclk();
        #3;
        burst_clk = 1'b1;
        #100;
        burst_clk = 1'b0;
        // Ends between clock edges; the caller's next falling edge
        // completes the 200 ns period without a race.
        #85;
    endtask
endmodule

// File: dv/flash_write_status_reporting_tb_top.sv
// Self-checking bench of the flash write status reporting block.
module flash_write_status_reporting_tb_top
    import flash_status_pkg::*;
();
    timeunit 1ns;
    timeprecision 1ps;
    localparam int unsigned PP = 200;   // Shortened protected hold.
    logic        ref_clk = 1'b0;        // Main clock.
    logic        resetn, burst_clk, ce_n, oe_n, we_n, sync_mode, wait_two;
    logic [21:0] burst_start_addr;      // First burst address.
    logic        prog_cmd, prog_protected, erase_cmd, erase_all_prot;
    logic        suspend_cmd, resume_cmd, algo_done, pulse_limit_hit;
    logic        reset_cmd, addr_busy_bank, addr_erase_sel;
    logic [7:0]  array_data, data_low_byte;
    logic        status_shown, rdy_out, rdy_oe, busy;
    int          n_mismatch = 0;        // Mismatches seen.
    int          checks = 0;            // Comparisons made.
    always #12.5 ref_clk = ~ref_clk;
    flash_write_status_reporting #(.PROG_PROT_CYCLES(PP))
    i_flash_write_status_reporting (
        .ref_clk(ref_clk), .resetn(resetn), .burst_clk(burst_clk),
        .ce_n(ce_n), .oe_n(oe_n), .we_n(we_n), .sync_mode(sync_mode),
        .wait_two(wait_two), .burst_start_addr(burst_start_addr),
        .prog_cmd(prog_cmd), .prog_protected(prog_protected),
        .erase_cmd(erase_cmd), .erase_all_prot(erase_all_prot),
        .suspend_cmd(suspend_cmd), .resume_cmd(resume_cmd),
        .algo_done(algo_done), .pulse_limit_hit(pulse_limit_hit),
        .reset_cmd(reset_cmd), .addr_busy_bank(addr_busy_bank),
        .addr_erase_sel(addr_erase_sel), .array_data(array_data),
        .data_low_byte(data_low_byte), .status_shown(status_shown),
        .rdy_out(rdy_out), .rdy_oe(rdy_oe), .busy(busy));
    flash_host_model i_flash_host_model (
        .ref_clk(ref_clk), .data_low_byte(data_low_byte), .ce_n(ce_n),
        .oe_n(oe_n), .we_n(we_n), .burst_clk(burst_clk));
    // ==========================================================
    // Compares one value and counts it.
    task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
        checks++;
        if (seen !== exp) begin
            n_mismatch++;
            $display("wrong value at %0t: saw %h, want %h", $time, seen, exp);
        end
    endtask
    // Prints the counts and the verdict, then ends the run.
    task automatic report_and_stop();
        $display("mismatches %0d, checks %0d", n_mismatch, checks);
        if (n_mismatch == 0 && checks > 0) begin
            $display("Finished cleanly");
        end else begin
            $display("Finished with errors");
        end
        $finish;
    endtask
    // Pin state as {busy, drive, level}.
    function automatic logic [7:0] st();
        return {5'h0, busy, rdy_oe, rdy_out};
    endfunction
    // Expected ready level after burst edge k from a start at 3Eh.
    function automatic logic exp_rdy(input int k, input logic two);
        return !(k < 3 || k == 5 || (k == 6 && two));
    endfunction
    // One-cycle pulse: 0 done, 1 suspend, 2 resume, 3 limit, 4 reset.
    task automatic pulse(input int k);
        @(negedge ref_clk);
        {reset_cmd, pulse_limit_hit, resume_cmd, suspend_cmd, algo_done} =
            5'(5'h1 << k);
        @(negedge ref_clk);
        {reset_cmd, pulse_limit_hit, resume_cmd, suspend_cmd, algo_done} =
            5'h0;
        repeat (6) @(negedge ref_clk);
    endtask
    // Arms {program, erase, protected} and gives the final strobe.
    task automatic wr(input logic [2:0] f);
        @(negedge ref_clk);
        {prog_cmd, erase_cmd, prog_protected} = f;
        i_flash_host_model.wr();
        {prog_cmd, erase_cmd, prog_protected} = 3'h0;
    endtask
    task automatic poll(input logic [7:0] x);
        logic [7:0] a0, b0, a1, b1;
        i_flash_host_model.rd(a0, b0);
        i_flash_host_model.rd(a1, b1);
        chk(b0, a0);
        chk(a1 ^ a0, x);
    endtask
    // A read of random array contents.
    task automatic rdata();
        logic [7:0] a, b;
        @(negedge ref_clk);
        array_data = 8'($urandom);
        i_flash_host_model.rd(a, b);
        chk(a, array_data);
    endtask
    initial begin
        #1000000;
        n_mismatch++;
        report_and_stop();
    end
    initial begin
        {sync_mode, wait_two, erase_all_prot, addr_erase_sel} = 4'h0;
        {prog_cmd, erase_cmd, prog_protected} = 3'h0;
        {reset_cmd, pulse_limit_hit, resume_cmd, suspend_cmd, algo_done} =
            5'h0;
        // Reads stay in the busy bank.
        addr_busy_bank = 1'b1;
        burst_start_addr = 22'h0;
        array_data = 8'h00;
        resetn = 1'b0;
        void'($urandom(32'hf8d93377));
        repeat (8) @(negedge ref_clk);
        resetn = 1'b1;
        repeat (4) @(negedge ref_clk);
        chk(st(), 8'h00);
        addr_erase_sel = 1'($urandom);
        wr(3'h4);
        chk(st(), 8'h06);
        poll(8'h40);
        pulse(0);
        rdata();
        chk(st(), 8'h00);
        wr(3'h4);
        pulse(3);
        i_flash_host_model.rd(array_data, burst_start_addr[7:0]);
        chk(array_data & 8'h20, 8'h20);
        poll(8'h40);
        pulse(4);
        rdata();
        wr(3'h5);
        chk(st(), 8'h00);
        poll(8'h40);
        repeat (PP) @(negedge ref_clk);
        rdata();
        addr_erase_sel = 1'b1;
        wr(3'h2);
        poll(8'h44);
        pulse(1);
        poll(8'h04);
        chk(st(), 8'h00);
        addr_erase_sel = 1'b0;
        rdata();
        wr(3'h4);
        chk(st(), 8'h06);
        poll(8'h40);
        pulse(0);
        addr_erase_sel = 1'b1;
        poll(8'h04);
        pulse(2);
        poll(8'h44);
        addr_erase_sel = 1'b0;
        poll(8'h40);
        pulse(0);
        rdata();
        erase_all_prot = 1'b1;
        wr(3'h2);
        poll(8'h40);
        repeat (4000) @(negedge ref_clk);
        rdata();
        erase_all_prot = 1'b0;
        sync_mode = 1'b1;
        for (int w = 0; w < 2; w++) begin
            wait_two = w[0];
            burst_start_addr = {16'($urandom), 6'h3e};
            i_flash_host_model.sel(1'b0);
            chk(st(), 8'h02);
            for (int k = 1; k < 9; k++) begin
                i_flash_host_model.bclk();
                @(negedge ref_clk);
                chk({7'h0, rdy_out}, {7'h0, exp_rdy(k, w[0])});
            end
            i_flash_host_model.sel(1'b1);
            chk(st(), 8'h01);
        end
        report_and_stop();
    end
endmodule
bind flash_write_status_reporting flash_status_checker #(
    .PROG_PROT_CYCLES(PROG_PROT_CYCLES)
) i_flash_status_checker (
    .ref_clk(ref_clk), .resetn(resetn), .ce_n(ce_n), .oe_n(oe_n),
    .we_n(we_n), .sync_mode(sync_mode), .prog_cmd(prog_cmd),
    .prog_protected(prog_protected), .algo_done(algo_done),
    .array_data(array_data), .data_low_byte(data_low_byte),
    .status_shown(status_shown), .rdy_out(rdy_out), .rdy_oe(rdy_oe),
    .busy(busy));
